/* File: src/accum_regs.svh */
// Register offsets, field positions and reset values of the accumulator
// control block. Assumes byte-wide registers on a plain strobe port.
`ifndef ACCUM_REGS_SVH
`define ACCUM_REGS_SVH

`define ACCUM_ADDR_W 8
`define ACCUM_CONTROL_OFF 8'h20
`define ACCUM_FLAG_OFF 8'h21
`define ACCUM_COUNT_HI_OFF 8'h22
`define ACCUM_COUNT_LO_OFF 8'h23
`define ACCUM_TIMER_CTRL_OFF 8'h24

`define ACCUM_CONTROL_RESET 8'h00
`define ACCUM_COUNT_RESET 16'h0000
`define ACCUM_COUNT_MAX 16'hffff
`define TIMER_CTRL_RESET 8'h00
`define FLAG_RESET 2'h0
`define FLAG_ALL 2'h3
`define PIN_SYNC_RESET 3'h0
`define PIN_PRIME_W 2
`define PIN_PRIME_LAST 2'h3
`define READ_IDLE 8'h00

`define BIT_ACCUM_ENABLE 6
`define BIT_ACCUM_MODE 5
`define BIT_ACCUM_EDGE 4
`define BIT_CLK_SEL_HI 3
`define BIT_CLK_SEL_LO 2
`define BIT_OVF_IRQ_EN 1
`define BIT_IN_IRQ_EN 0
`define BIT_OVERFLOW_FLAG 1
`define BIT_INPUT_FLAG 0
`define BIT_TIMER_ENABLE 7
`define BIT_FAST_CLEAR 4

`define CONTROL_MASK 8'h7f
`define TIMER_CTRL_MASK 8'h90
`define FLAG_MASK 8'h03

`define PRESCALE_DIV64_W 6
`define PRESCALE_DIV64_LAST 6'h3f
`define ACCUM_DIV256_W 8
`define ACCUM_DIV256_LAST 8'hff
`define ACCUM_DIV65536_W 16
`define ACCUM_DIV65536_LAST 16'hffff

`endif

/* File: src/accum_pkg.sv */
// Types shared by the accumulator control block.
// Assumes the register header is included by the design file.
package accum_pkg;

	typedef enum logic [1:0] {
		clk_sel_prescaler = 2'h0,
		clk_sel_accum = 2'h1,
		clk_sel_accum_div256 = 2'h2,
		clk_sel_accum_div65536 = 2'h3
	} clk_sel_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

	typedef struct packed {
		logic accum_enable;
		logic accum_mode_select;
		logic accum_edge_select;
		clk_sel_type clk_sel;
		logic overflow_irq_enable;
		logic input_irq_enable;
	} control_type;

	typedef enum logic [2:0] {
		st_disabled = 3'h1,
		st_event = 3'h2,
		st_gated = 3'h4
	} accum_state_type;

endpackage : accum_pkg

/* File: src/pulse_accumulator_control.sv */
// Pulse accumulator control, flags, count and timer clock source.
// Assumes one bus clock, synchronous reset and a byte register port with
// read data one cycle after the read strobe. The channel 7 pin is async.
`timescale 1ns/1ns
`default_nettype none
`include "accum_regs.svh"

// Function
// R01: Enable bit gates accumulator, independent of timer
// R02: Input taken from shared channel 7 pin
// R03: Mode bit: 0 event, 1 gated
// R04: Edge select: 0 falling, 1 rising counts
// R05: Gated, edge 0: high gates div64, falling flags
// R06: Gated, edge 1: low gates div64, rising flags
// R07: No gated counting while timer disabled
// R08: Clock select picks timer counter clock source
// R09: Accumulator disabled forces prescaler clock
// R10: Clock select change takes effect immediately
// R11: Overflow enable requests interrupt on overflow flag
// R12: Input enable requests interrupt on edge flag
// R13: Writing one to bit 1 clears overflow
// R14: Edge flag sets on counted or trailing edge
// R15: Writing one to bit 0 clears edge flag
// R16: Fast clear: count access clears all flags
// R17: Count rollover to zero sets overflow flag
// R18: Input pulses exceed two bus clocks
// R19: Accumulator clock is the increment strobe
module pulse_accumulator_control (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic channel7_pin_i,
	input wire logic prescaler_tick_i,
	output logic timer_count_tick_o,
	output logic accum_clock_o,
	output logic [15:0] accum_count_o,
	output logic irq_o
);

	accum_pkg::bus_req_type req;
	accum_pkg::control_type ctl;
	accum_pkg::accum_state_type state_reg;
	accum_pkg::accum_state_type state_next;

	logic [7:0] accum_control_reg;
	logic [7:0] accum_control_next;
	logic [7:0] timer_system_control_reg;
	logic [7:0] timer_system_control_next;
	logic [1:0] accum_flag_reg;
	logic [1:0] accum_flag_next;
	logic [15:0] accum_count_reg;
	logic [15:0] accum_count_next;
	logic [2:0] pin_sync_reg;
	logic [`PIN_PRIME_W-1:0] pin_prime_reg;
	logic pin_level_reg;
	logic [`PRESCALE_DIV64_W-1:0] div64_reg;
	logic [`ACCUM_DIV256_W-1:0] div256_reg;
	logic [`ACCUM_DIV65536_W-1:0] div65536_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	logic timer_enable;
	logic fast_flag_clear;
	logic pin_primed;
	logic pin_agree;
	logic pin_rise;
	logic pin_fall;
	logic counted_edge;
	logic trailing_edge;
	logic gate_active;
	logic div64_tick;
	logic accum_inc;
	logic overflow_event;
	logic input_event;
	logic count_access;
	logic flag_write;
	logic [1:0] flag_clear;
	logic div256_tick;
	logic div65536_tick;
	logic count_write;

	assign req.addr = addr_i;
	assign req.wdata = wdata_i;
	assign req.wr = wr_i;
	assign req.rd = rd_i;

	assign ctl.accum_enable = accum_control_reg[`BIT_ACCUM_ENABLE];
	assign ctl.accum_mode_select = accum_control_reg[`BIT_ACCUM_MODE];
	assign ctl.accum_edge_select = accum_control_reg[`BIT_ACCUM_EDGE];
	assign ctl.clk_sel = accum_pkg::clk_sel_type'(
		accum_control_reg[`BIT_CLK_SEL_HI:`BIT_CLK_SEL_LO]);
	assign ctl.overflow_irq_enable = accum_control_reg[`BIT_OVF_IRQ_EN];
	assign ctl.input_irq_enable = accum_control_reg[`BIT_IN_IRQ_EN];

	assign timer_enable = timer_system_control_reg[`BIT_TIMER_ENABLE];
	assign fast_flag_clear = timer_system_control_reg[`BIT_FAST_CLEAR];

	// Pin synchroniser, level moves once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pin_sync_reg <= `PIN_SYNC_RESET;
		else
			pin_sync_reg <= {pin_sync_reg[1:0], channel7_pin_i}; // R02
	end

	assign pin_agree = (pin_sync_reg[1] == pin_sync_reg[2]);

	// No edges until the chain has refilled after reset
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pin_prime_reg <= '0;
		else if (!pin_primed)
			pin_prime_reg <= pin_prime_reg + 1'b1;
	end

	assign pin_primed = (pin_prime_reg == `PIN_PRIME_LAST);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pin_level_reg <= 1'b0;
		else if (!pin_primed)
			pin_level_reg <= pin_sync_reg[1];
		else if (pin_agree)
			pin_level_reg <= pin_sync_reg[2]; // R18
	end

	assign pin_rise = pin_primed && pin_agree && pin_sync_reg[2] &&
		!pin_level_reg;
	assign pin_fall = pin_primed && pin_agree && !pin_sync_reg[2] &&
		pin_level_reg;

	// Operating state tracks the control byte as it is written
	always_comb
	begin
		if (!accum_control_next[`BIT_ACCUM_ENABLE])
			state_next = accum_pkg::st_disabled; // R01
		else if (accum_control_next[`BIT_ACCUM_MODE])
			state_next = accum_pkg::st_gated; // R03
		else
			state_next = accum_pkg::st_event; // R03
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			state_reg <= accum_pkg::st_disabled;
		else
			state_reg <= state_next;
	end

	// Divide-by-64 stage of the timer prescaler
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			div64_reg <= '0;
		else if (timer_enable && prescaler_tick_i)
			div64_reg <= div64_reg + 1'b1; // R07
	end

	assign div64_tick = timer_enable && prescaler_tick_i &&
		(div64_reg == `PRESCALE_DIV64_LAST); // R07

	assign counted_edge = ctl.accum_edge_select ? pin_rise : pin_fall; // R04
	assign trailing_edge = ctl.accum_edge_select ? pin_rise : pin_fall;
	assign gate_active = ctl.accum_edge_select ? !pin_level_reg
		: pin_level_reg; // R05 R06

	always_comb
	begin
		accum_inc = 1'b0;
		input_event = 1'b0;
		case (state_reg)
			accum_pkg::st_disabled:
			begin
				accum_inc = 1'b0; // R01
				input_event = 1'b0;
			end
			accum_pkg::st_event:
			begin
				accum_inc = counted_edge; // R04
				input_event = counted_edge; // R14
			end
			accum_pkg::st_gated:
			begin
				accum_inc = gate_active && div64_tick; // R05 R06 R07
				input_event = trailing_edge; // R05 R06 R14
			end
			default:
			begin
				accum_inc = 1'b0;
				input_event = 1'b0;
			end
		endcase
	end

	assign accum_clock_o = accum_inc; // R19

	// Count register, a byte write beats the increment
	assign count_write = req.wr &&
		(req.addr == `ACCUM_COUNT_HI_OFF ||
		req.addr == `ACCUM_COUNT_LO_OFF);
	assign overflow_event = accum_inc && !count_write &&
		(accum_count_reg == `ACCUM_COUNT_MAX); // R17

	always_comb
	begin
		accum_count_next = accum_count_reg;
		if (req.wr && req.addr == `ACCUM_COUNT_HI_OFF)
			accum_count_next = {req.wdata, accum_count_reg[7:0]};
		else if (req.wr && req.addr == `ACCUM_COUNT_LO_OFF)
			accum_count_next = {accum_count_reg[15:8], req.wdata};
		else if (accum_inc)
			accum_count_next = accum_count_reg + 1'b1; // R17
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			accum_count_reg <= `ACCUM_COUNT_RESET;
		else
			accum_count_reg <= accum_count_next;
	end

	assign accum_count_o = accum_count_reg;

	// Timer clock dividers fed by the accumulator clock
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			div256_reg <= '0;
		else if (accum_inc)
			div256_reg <= div256_reg + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			div65536_reg <= '0;
		else if (accum_inc)
			div65536_reg <= div65536_reg + 1'b1;
	end

	assign div256_tick = accum_inc &&
		(div256_reg == `ACCUM_DIV256_LAST);
	assign div65536_tick = accum_inc &&
		(div65536_reg == `ACCUM_DIV65536_LAST);

	// Timer counter clock, selected combinationally from the live field
	always_comb
	begin
		timer_count_tick_o = prescaler_tick_i && timer_enable;
		if (ctl.accum_enable) // R09
		begin
			case (ctl.clk_sel) // R08 R10
				accum_pkg::clk_sel_prescaler:
					timer_count_tick_o = prescaler_tick_i && timer_enable;
				accum_pkg::clk_sel_accum:
					timer_count_tick_o = accum_inc;
				accum_pkg::clk_sel_accum_div256:
					timer_count_tick_o = div256_tick;
				accum_pkg::clk_sel_accum_div65536:
					timer_count_tick_o = div65536_tick;
				default:
					timer_count_tick_o = prescaler_tick_i && timer_enable;
			endcase
		end
	end

	// Flags: set wins over any clear in the same cycle
	assign count_access = (req.wr || req.rd) &&
		(req.addr == `ACCUM_COUNT_HI_OFF ||
		req.addr == `ACCUM_COUNT_LO_OFF);
	assign flag_write = req.wr && (req.addr == `ACCUM_FLAG_OFF);

	always_comb
	begin
		flag_clear = 2'h0;
		if (flag_write)
		begin
			flag_clear[`BIT_OVERFLOW_FLAG] =
				req.wdata[`BIT_OVERFLOW_FLAG]; // R13
			flag_clear[`BIT_INPUT_FLAG] = req.wdata[`BIT_INPUT_FLAG]; // R15
		end
		if (fast_flag_clear && count_access)
			flag_clear = `FLAG_ALL; // R16
	end

	always_comb
	begin
		accum_flag_next = accum_flag_reg & ~flag_clear;
		if (overflow_event)
			accum_flag_next[`BIT_OVERFLOW_FLAG] = 1'b1; // R17
		if (input_event)
			accum_flag_next[`BIT_INPUT_FLAG] = 1'b1; // R14
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			accum_flag_reg <= `FLAG_RESET;
		else
			accum_flag_reg <= accum_flag_next;
	end

	assign irq_o = (ctl.overflow_irq_enable &&
		accum_flag_reg[`BIT_OVERFLOW_FLAG]) || // R11
		(ctl.input_irq_enable && accum_flag_reg[`BIT_INPUT_FLAG]); // R12

	// Control registers
	always_comb
	begin
		accum_control_next = accum_control_reg;
		if (req.wr && req.addr == `ACCUM_CONTROL_OFF)
			accum_control_next = req.wdata & `CONTROL_MASK; // R10
	end

	always_comb
	begin
		timer_system_control_next = timer_system_control_reg;
		if (req.wr && req.addr == `ACCUM_TIMER_CTRL_OFF)
			timer_system_control_next = req.wdata & `TIMER_CTRL_MASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			accum_control_reg <= `ACCUM_CONTROL_RESET;
		else
			accum_control_reg <= accum_control_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			timer_system_control_reg <= `TIMER_CTRL_RESET;
		else
			timer_system_control_reg <= timer_system_control_next;
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_comb
	begin
		rdata_next = `READ_IDLE;
		if (req.rd)
		begin
			case (req.addr)
				`ACCUM_CONTROL_OFF:
					rdata_next = accum_control_reg;
				`ACCUM_FLAG_OFF:
					rdata_next = {6'h00, accum_flag_reg};
				`ACCUM_COUNT_HI_OFF:
					rdata_next = accum_count_reg[15:8];
				`ACCUM_COUNT_LO_OFF:
					rdata_next = accum_count_reg[7:0];
				`ACCUM_TIMER_CTRL_OFF:
					rdata_next = timer_system_control_reg;
				default:
					rdata_next = `READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_reg <= `READ_IDLE;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata_o = rdata_reg;

endmodule : pulse_accumulator_control
`default_nettype wire

/* File: tb/accum_pin_source.sv */
// Far-side model: the source driving the shared channel 7 pin.
// Assumes calls from the bench just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module accum_pin_source (
	input wire logic clk_i,
	output logic pin_o
);
	initial pin_o = 1'b0;
	// Level held whole cycles, never under three
	task hold(input logic v, input int n);
		pin_o <= v;
		repeat ((n < 3) ? 3 : n) @(posedge clk_i);
	endtask : hold
endmodule : accum_pin_source
`default_nettype wire

/* File: tb/accum_chk.sv */
// Concurrent checks on the accumulator control ports.
// Assumes the bind below and the control map at 0x20 and 0x24.
`timescale 1ns/1ns
`default_nettype none
module accum_chk (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic channel7_pin_i,
	input wire logic prescaler_tick_i,
	input wire logic timer_count_tick_o,
	input wire logic accum_clock_o,
	input wire logic [15:0] accum_count_o,
	input wire logic irq_o
);
	logic [7:0] ctl_reg;
	logic ten_reg;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Shadow of control and timer enable
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctl_reg <= 8'h00;
			ten_reg <= 1'b0;
		end
		else if (wr_i && addr_i == 8'h20)
			ctl_reg <= wdata_i & 8'h7f;
		else if (wr_i && addr_i == 8'h24)
			ten_reg <= wdata_i[7];
	end
	property p_dis_src;
		!ctl_reg[6] |-> timer_count_tick_o == (prescaler_tick_i && ten_reg);
	endproperty
	a_dis_src: assert property (p_dis_src)
		else $error("tick not from prescaler");
	property p_sel_acc;
		ctl_reg[6] && ctl_reg[3:2] == 2'h1 |->
			timer_count_tick_o == accum_clock_o;
	endproperty
	a_sel_acc: assert property (p_sel_acc)
		else $error("tick not accumulator clock");
	property p_inc;
		accum_clock_o && !(wr_i && addr_i[7:1] == 7'h11) |=>
			accum_count_o == $past(accum_count_o) + 16'h0001;
	endproperty
	a_inc: assert property (p_inc)
		else $error("count not incremented");
	property p_off;
		!ctl_reg[6] |-> !accum_clock_o;
	endproperty
	a_off: assert property (p_off)
		else $error("count while disabled");
	property p_no_div;
		ctl_reg[6] && ctl_reg[5] && !ten_reg |-> !accum_clock_o;
	endproperty
	a_no_div: assert property (p_no_div)
		else $error("gated count with timer off");
	property p_mask;
		ctl_reg[1:0] == 2'h0 |-> !irq_o;
	endproperty
	a_mask: assert property (p_mask)
		else $error("irq while masked");
	property p_rise;
		$rose(channel7_pin_i) && ctl_reg[6:4] == 3'h5 |-> ##[2:5] accum_clock_o;
	endproperty
	a_rise: assert property (p_rise)
		else $error("rising edge not counted");
	property p_clear;
		wr_i && addr_i == 8'h21 && wdata_i[1:0] == 2'h3 && !accum_clock_o
			|=> !irq_o;
	endproperty
	a_clear: assert property (p_clear)
		else $error("flags not cleared");
	c_irq: cover property (irq_o);
	c_gated: cover property (accum_clock_o && ctl_reg[5]);
	c_sel: cover property (timer_count_tick_o && ctl_reg[3:2] == 2'h1);
endmodule : accum_chk
bind pulse_accumulator_control accum_chk chk (.clk_i, .srst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .channel7_pin_i, .prescaler_tick_i,
	.timer_count_tick_o, .accum_clock_o, .accum_count_o, .irq_o);
`default_nettype wire

/* File: tb/pulse_accumulator_control_test.sv */
// Self-checking bench for the accumulator control block.
// Assumes the pin source model and the checker bind.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("unexpected %s exp %h got %h", n, e, g); \
		end \
	end
module pulse_accumulator_control_test;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic [7:0] d;
	logic pin;
	logic tick;
	logic aclk;
	logic irq_o;
	logic pre_tick = 1'b1;
	logic [15:0] cnt;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int ticks = 0;
	accum_pin_source src (.clk_i(clk_i), .pin_o(pin));
	pulse_accumulator_control dut (.clk_i(clk_i), .srst_i(srst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .channel7_pin_i(pin), .prescaler_tick_i(pre_tick),
		.timer_count_tick_o(tick), .accum_clock_o(aclk),
		.accum_count_o(cnt), .irq_o(irq_o));
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (tick === 1'b1)
			ticks++;
		if (cyc == 20000)
		begin
			err_count++;
			close_out();
		end
	end
	task close_out();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task pulses(input int n);
		repeat (n)
		begin
			src.hold(1'b1, 4);
			src.hold(1'b0, 4);
		end
		repeat (4) @(posedge clk_i);
		#1;
	endtask : pulses
	task t_regs();
		rd(8'h20);
		`CHK("control", 8'h00, d)
		rd(8'h21);
		`CHK("flags", 8'h00, d)
		wr(8'h20, 8'hff);
		rd(8'h20);
		`CHK("control", 8'h7f, d)
		rd(8'h30);
		`CHK("unmapped", 8'h00, d)
		wr(8'h20, 8'h00);
	endtask : t_regs
	task t_event();
		wr(8'h20, 8'h50);
		pulses(3);
		`CHK("count", 16'h0003, cnt)
		rd(8'h21);
		`CHK("flags", 8'h01, d)
		wr(8'h20, 8'h40);
		wr(8'h21, 8'h01);
		rd(8'h21);
		`CHK("flags", 8'h00, d)
		pulses(2);
		`CHK("count", 16'h0005, cnt)
		`CHK("irq", 1'b0, irq_o)
		wr(8'h20, 8'h41);
		`CHK("irq", 1'b1, irq_o)
		wr(8'h21, 8'h01);
		`CHK("irq", 1'b0, irq_o)
	endtask : t_event
	task t_ovf();
		wr(8'h22, 8'hff);
		wr(8'h23, 8'hff);
		wr(8'h20, 8'h42);
		pulses(1);
		`CHK("count", 16'h0000, cnt)
		`CHK("irq", 1'b1, irq_o)
		wr(8'h21, 8'h02);
		rd(8'h21);
		`CHK("flags", 8'h01, d)
		`CHK("irq", 1'b0, irq_o)
		wr(8'h24, 8'h10);
		rd(8'h23);
		rd(8'h21);
		`CHK("flags", 8'h00, d)
		pulses(1);
		wr(8'h22, 8'h00);
		rd(8'h21);
		`CHK("flags", 8'h00, d)
		wr(8'h24, 8'h00);
	endtask : t_ovf
	task t_gated();
		wr(8'h22, 8'h00);
		wr(8'h23, 8'h00);
		wr(8'h24, 8'h80);
		wr(8'h20, 8'h60);
		src.hold(1'b1, 192);
		src.hold(1'b0, 8);
		`CHK("count", 16'h0003, cnt)
		rd(8'h21);
		`CHK("flags", 8'h01, d)
		wr(8'h24, 8'h00);
		src.hold(1'b1, 4);
		wr(8'h20, 8'h70);
		wr(8'h23, 8'h00);
		wr(8'h21, 8'h03);
		wr(8'h24, 8'h80);
		src.hold(1'b0, 128);
		src.hold(1'b1, 8);
		`CHK("count", 16'h0002, cnt)
		rd(8'h21);
		`CHK("flags", 8'h01, d)
		wr(8'h24, 8'h00);
		src.hold(1'b0, 128);
		src.hold(1'b1, 8);
		`CHK("count", 16'h0002, cnt)
	endtask : t_gated
	task t_clksel();
		wr(8'h24, 8'h80);
		wr(8'h20, 8'h44);
		ticks = 0;
		pulses(2);
		`CHK("ticks", 2, ticks)
		wr(8'h20, 8'h48);
		ticks = 0;
		pulses(256);
		`CHK("ticks", 1, ticks)
		wr(8'h20, 8'h4c);
		ticks = 0;
		pulses(2);
		`CHK("ticks", 0, ticks)
		wr(8'h20, 8'h0c);
		ticks = 0;
		repeat (10) @(posedge clk_i);
		#1;
		`CHK("ticks", 10, ticks)
		@(posedge clk_i);
		pre_tick <= 1'b0;
		#1 ticks = 0;
		repeat (10) @(posedge clk_i);
		#1;
		`CHK("ticks", 0, ticks)
		pre_tick <= 1'b1;
	endtask : t_clksel
	task t_reset();
		wr(8'h20, 8'h51);
		src.hold(1'b1, 8);
		#1;
		`CHK("irq", 1'b1, irq_o)
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		`CHK("irq", 1'b0, irq_o)
		`CHK("count", 16'h0000, cnt)
		rd(8'h20);
		`CHK("control", 8'h00, d)
		wr(8'h20, 8'h50);
		repeat (8) @(posedge clk_i);
		#1;
		`CHK("count", 16'h0000, cnt)
		src.hold(1'b0, 4);
		src.hold(1'b1, 8);
		#1;
		`CHK("count", 16'h0001, cnt)
	endtask : t_reset
	initial
	begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		t_regs();
		t_event();
		t_ovf();
		t_gated();
		t_clksel();
		t_reset();
		close_out();
	end
endmodule : pulse_accumulator_control_test
`default_nettype wire
